// ===== rtl/ring_mode_consts.svh
// Constants for the ring engine mode register block.
// Assumes inclusion by the package and the design module only.
`ifndef RING_MODE_CONSTS_SVH
`define RING_MODE_CONSTS_SVH
`define MODE_REG_ADDR      9'h000
`define MODE_REG_RESET     8'h00
`define MODE_BIT_DIAGNOSE_ENABLE      7
`define MODE_BIT_LOOPBACK  6
`define MODE_BIT_PHY_PAR   3
`define MODE_BIT_MAC_PAR   2
`define MODE_BIT_CB_PAR    1
`define MODE_BIT_RUN       0
`define MODE_WRITE_MASK    8'hCF
`define IDLE_BYTE          8'h00
`define IDLE_CTRL          1'b1
`endif

// ===== rtl/ring_mode_pkg.sv
// Types for the ring engine mode register block.
// Assumes the constants header is in the include path.
`include "ring_mode_consts.svh"
package ring_mode_pkg;
    typedef struct packed {
        logic       par;
        logic       ctrl;
        logic [7:0] data;
    } phy_byte_t;
    typedef enum logic [1:0] {
        SRC_IDLE,
        SRC_REPEAT,
        SRC_GENERATE
    } tx_src_t;
endpackage

// ===== rtl/ring_engine_mode_control.sv
// Mode register and PHY/MAC byte path of the ring engine.
// Assumes all inputs synchronous to clk_sys; host bus is a simple strobe bus.
`include "ring_mode_consts.svh"

// Overview of operation
// - Eight-bit mode register at 000h, always accessible
// - Diagnose bit opens all registers to host
// - Diagnose error freezes rx/tx status until cleared
// - Loopback feeds request outputs back, ignores PHY
// - Transmitter and receiver run independently except when repeating or in loopback
// - Parity enable checks odd parity on indicate
// - Indicate parity error becomes Idle, code violation
// - Repeated bytes pass indicate parity through
// - Generated fields carry odd request parity
// - Request data has odd parity unless a repeated byte has bad parity with the parity check off
// - Run clear forces stop and Idle transmit
// - MAC request parity checked; indicate parity generated
// - Control bus reads always carry parity
module ring_engine_mode_control
    import ring_mode_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Host control bus
    input  wire logic [8:0] cb_addr,
    input  wire logic       cb_write,
    input  wire logic       cb_read,
    input  wire logic [7:0] cb_wdata,
    output logic [7:0]      control_bus_data_lines,
    output logic            cb_rdata_parity,
    // Mode outputs
    output logic            diagnose_enable,
    output logic            all_regs_access,
    output logic            run_mode,
    output logic            control_bus_parity_check_enable,
    // Internal state machine status
    input  wire logic [7:0] rx_status_live,
    input  wire logic [7:0] tx_status_live,
    input  wire logic       receive_sm_error_flag,
    input  wire logic       transmit_sm_error_flag,
    output logic [7:0]      rx_status,
    output logic [7:0]      tx_status,
    // PHY indicate input
    input  phy_byte_t       phy_indicate_in,
    // Receive stream to ring engine
    output phy_byte_t       rx_byte,
    output logic            rx_code_violation,
    // Transmit stream from ring engine
    input  tx_src_t         tx_source,
    input  wire logic [7:0] tx_gen_data,
    input  wire logic       tx_gen_ctrl,
    // PHY request output
    output phy_byte_t       phy_request_out,
    // MAC request and indicate
    input  wire logic [7:0] mac_request_data_in,
    input  wire logic       mac_request_parity_in,
    input  wire logic       mac_request_valid,
    output logic            mac_tx_abort,
    output logic            mac_indicate_parity_out
);

    // ==========================================================
    // Mode register
    logic [7:0] ring_mode_register_zero;
    wire        hit_mode = cb_addr == `MODE_REG_ADDR;
    wire [7:0]  next_mode = cb_wdata & `MODE_WRITE_MASK;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ring_mode_register_zero <= `MODE_REG_RESET;
        end else if (cb_write && hit_mode) begin
            ring_mode_register_zero <= next_mode;
        end
    end

    wire diagnose_enable_bit     = ring_mode_register_zero[`MODE_BIT_DIAGNOSE_ENABLE];
    wire loopback_bit = ring_mode_register_zero[`MODE_BIT_LOOPBACK];
    wire phy_par_bit  = ring_mode_register_zero[`MODE_BIT_PHY_PAR];
    wire mac_par_bit  = ring_mode_register_zero[`MODE_BIT_MAC_PAR];
    wire run_bit      = ring_mode_register_zero[`MODE_BIT_RUN];

    assign diagnose_enable                 = diagnose_enable_bit;
    assign all_regs_access                 = diagnose_enable_bit;
    assign run_mode                        = run_bit;
    assign control_bus_parity_check_enable = ring_mode_register_zero[`MODE_BIT_CB_PAR];

    // ==========================================================
    // Read path, parity always generated
    wire [7:0] rd_value = hit_mode ? ring_mode_register_zero : 8'h00;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            control_bus_data_lines <= 8'h00;
            cb_rdata_parity        <= 1'b1;
        end else if (cb_read) begin
            control_bus_data_lines <= rd_value;
            cb_rdata_parity        <= ~^rd_value;
        end
    end

    // ==========================================================
    // Status freeze: error state held in diagnose mode while flags stay set
    wire freeze_rx = diagnose_enable_bit && receive_sm_error_flag;
    wire freeze_tx = diagnose_enable_bit && transmit_sm_error_flag;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_status <= 8'h00;
            tx_status <= 8'h00;
        end else begin
            if (!freeze_rx) rx_status <= rx_status_live;
            if (!freeze_tx) tx_status <= tx_status_live;
        end
    end

    // ==========================================================
    // Receive path with loopback and parity check
    // Loopback taps the registered request byte, so it trails by one cycle.
    wire phy_byte_t rx_src = loopback_bit ? phy_request_out : phy_indicate_in;
    wire rx_par_bad = phy_par_bit && (^{rx_src.par, rx_src.data} == 1'b0);

    phy_byte_t idle_byte;
    assign idle_byte = '{par: ~^`IDLE_BYTE, ctrl: `IDLE_CTRL, data: `IDLE_BYTE};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_byte           <= '{par: 1'b1, ctrl: `IDLE_CTRL, data: `IDLE_BYTE};
            rx_code_violation <= 1'b0;
        end else begin
            rx_byte           <= rx_par_bad ? idle_byte : rx_src;
            rx_code_violation <= rx_par_bad;
        end
    end

    // ==========================================================
    // Transmit path, independent of receive except when repeating
    phy_byte_t next_req;
    always_comb begin
        next_req = idle_byte;
        if (run_bit) begin
            case (tx_source)
                SRC_REPEAT:   next_req = rx_byte;
                SRC_GENERATE: next_req = '{par: ~^tx_gen_data, ctrl: tx_gen_ctrl,
                                           data: tx_gen_data};
                SRC_IDLE:     next_req = idle_byte;
                default:      next_req = idle_byte;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phy_request_out <= '{par: 1'b1, ctrl: `IDLE_CTRL, data: `IDLE_BYTE};
        end else begin
            phy_request_out <= next_req;
        end
    end

    // ==========================================================
    // MAC request parity check and indicate parity
    wire mac_par_bad = mac_par_bit && mac_request_valid
                       && (^{mac_request_parity_in, mac_request_data_in} == 1'b0);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mac_tx_abort            <= 1'b0;
            mac_indicate_parity_out <= 1'b1;
        end else begin
            mac_tx_abort            <= mac_par_bad;
            mac_indicate_parity_out <= ~^rx_byte.data;
        end
    end

    // ==========================================================
    // Checks
    a_reserved_read_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (ring_mode_register_zero[5:4] == 2'b00))
        else $error("reserved mode bits not zero");
    a_mode_write_lands: assert property (@(posedge clk_sys) disable iff (rst)
        (cb_write && hit_mode) |=>
        ring_mode_register_zero == ($past(cb_wdata) & `MODE_WRITE_MASK))
        else $error("mode write not stored");
    a_read_parity_odd: assert property (@(posedge clk_sys) disable iff (rst)
        cb_read |=> ^{cb_rdata_parity, control_bus_data_lines})
        else $error("read parity not odd");
    a_rx_status_frozen: assert property (@(posedge clk_sys) disable iff (rst)
        freeze_rx |=> $stable(rx_status))
        else $error("rx status changed while frozen");
    a_tx_status_frozen: assert property (@(posedge clk_sys) disable iff (rst)
        freeze_tx |=> $stable(tx_status))
        else $error("tx status changed while frozen");
    a_parity_err_idle: assert property (@(posedge clk_sys) disable iff (rst)
        rx_par_bad |=> (rx_byte.data == `IDLE_BYTE && rx_code_violation))
        else $error("bad byte not replaced by idle");
    a_stop_sends_idle: assert property (@(posedge clk_sys) disable iff (rst)
        !run_bit |=> phy_request_out.data == `IDLE_BYTE && phy_request_out.ctrl)
        else $error("stop mode not idle");
    a_repeat_parity_pass: assert property (@(posedge clk_sys) disable iff (rst)
        (run_bit && tx_source == SRC_REPEAT) |=> phy_request_out.par == $past(rx_byte.par))
        else $error("repeat parity altered");
    a_gen_parity_odd: assert property (@(posedge clk_sys) disable iff (rst)
        (!run_bit || tx_source != SRC_REPEAT) |=> ^{phy_request_out.par, phy_request_out.data})
        else $error("generated parity not odd");
    a_loopback_ignores_phy: assert property (@(posedge clk_sys) disable iff (rst)
        (loopback_bit && !rx_par_bad) |=> rx_byte == $past(phy_request_out))
        else $error("loopback not taken");
    a_mac_abort_parity: assert property (@(posedge clk_sys) disable iff (rst)
        (mac_par_bit && mac_request_valid && !(^{mac_request_parity_in, mac_request_data_in}))
        |=> mac_tx_abort)
        else $error("mac parity error not aborted");
    a_abort_needs_error: assert property (@(posedge clk_sys) disable iff (rst)
        !mac_par_bad |=> !mac_tx_abort)
        else $error("mac abort without parity error");
    a_mac_ind_parity: assert property (@(posedge clk_sys) disable iff (rst)
        ^{mac_indicate_parity_out, $past(rx_byte.data)})
        else $error("mac indicate parity not odd");
    // Sampled reset keeps the release edge out, where rx_byte is still the reset idle
    a_clean_byte_passes: assert property (@(posedge clk_sys) disable iff (rst)
        (!rst && !rx_par_bad && !loopback_bit) |=>
        (rx_byte == $past(phy_indicate_in) && !rx_code_violation))
        else $error("clean byte not passed");

endmodule

// ===== tb/phy_far_end.sv
// Far-side PHY model that drives the indicate byte every cycle.
// Assumes the bench supplies the byte and a flag that spoils its parity.
module phy_far_end
    import ring_mode_pkg::*;
(
    // Clock
    input  wire logic       clk_sys,
    // Byte to send
    input  wire logic [7:0] snd_data,
    input  wire logic       snd_ctrl,
    input  wire logic       spoil,
    // Indicate bus
    output phy_byte_t       ind
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Odd parity unless spoiled on purpose
    always @(posedge clk_sys) begin
        ind <= '{par: ~^snd_data ^ spoil, ctrl: snd_ctrl, data: snd_data};
    end
endmodule

// ===== tb/ring_engine_mode_control_tb.sv
// Self-checking bench for the mode register and PHY/MAC byte path.
// Assumes the package is compiled first; steady values are checked.
module ring_engine_mode_control_tb;
    import ring_mode_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct { int when; int sel; logic [9:0] v; } note_t;
    logic clk_sys = 1'h0, rst = 1'h1, cb_write = 1'h0, cb_read = 1'h0;
    logic [8:0] cb_addr = 9'h000;
    logic [7:0] cb_wdata = 8'h00, rx_status_live = 8'h00, tx_status_live = 8'h00;
    logic receive_sm_error_flag = 1'h0, transmit_sm_error_flag = 1'h0;
    tx_src_t tx_source = SRC_IDLE;
    logic [7:0] tx_gen_data = 8'h00, mac_request_data_in = 8'h00, snd_data = 8'h00;
    logic tx_gen_ctrl = 1'h0, mac_request_parity_in = 1'h0, mac_request_valid = 1'h0;
    logic snd_ctrl = 1'h0, spoil = 1'h0;
    logic [7:0] control_bus_data_lines, rx_status, tx_status;
    logic cb_rdata_parity, diagnose_enable, all_regs_access, run_mode;
    logic control_bus_parity_check_enable, rx_code_violation, mac_tx_abort;
    logic mac_indicate_parity_out;
    phy_byte_t phy_indicate_in, rx_byte, phy_request_out;
    note_t notes[$];
    int mcyc = 0, cycles = 0, err_total = 0, n_compared = 0;
    logic [7:0] d, g;
    ring_engine_mode_control ring_engine_mode_control_inst (.clk_sys, .rst, .cb_addr,
        .cb_write, .cb_read, .cb_wdata, .control_bus_data_lines, .cb_rdata_parity,
        .diagnose_enable, .all_regs_access, .run_mode, .control_bus_parity_check_enable,
        .rx_status_live, .tx_status_live, .receive_sm_error_flag, .transmit_sm_error_flag,
        .rx_status, .tx_status, .phy_indicate_in, .rx_byte, .rx_code_violation,
        .tx_source, .tx_gen_data, .tx_gen_ctrl, .phy_request_out, .mac_request_data_in,
        .mac_request_parity_in, .mac_request_valid, .mac_tx_abort, .mac_indicate_parity_out);
    phy_far_end phy_far_end_inst (.clk_sys(clk_sys), .snd_data(snd_data),
        .snd_ctrl(snd_ctrl), .spoil(spoil), .ind(phy_indicate_in));
    // ==========================================
    // Clock, timeout and result watcher
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            final_report();
        end
    end
    function automatic logic odd(logic [7:0] x);
        return ~^x;
    endfunction
    function automatic logic [9:0] seen(int s);
        case (s)
            0: return {1'h0, cb_rdata_parity, control_bus_data_lines};
            1: return rx_byte;
            2: return phy_request_out;
            3: return {9'h000, rx_code_violation};
            4: return {6'h00, diagnose_enable, all_regs_access, run_mode,
                       control_bus_parity_check_enable};
            5: return {2'h0, rx_status};
            6: return {9'h000, mac_tx_abort};
            7: return {9'h000, mac_indicate_parity_out};
            default: return {2'h0, tx_status};
        endcase
    endfunction
    function automatic string what(int s);
        case (s)
            0: return "read_data";
            1: return "rx_byte";
            2: return "phy_request_out";
            3: return "rx_code_violation";
            4: return "mode_outputs";
            5: return "rx_status";
            6: return "mac_tx_abort";
            7: return "mac_indicate_parity_out";
            default: return "tx_status";
        endcase
    endfunction
    task automatic check(string name, logic [9:0] s, logic [9:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, e, s);
        end
    endtask
    // Oldest note is due at this falling edge, when outputs have settled
    always @(negedge clk_sys) begin
        mcyc = mcyc + 1;
        while (notes.size() > 0 && notes[0].when == mcyc) begin
            check(what(notes[0].sel), seen(notes[0].sel), notes[0].v);
            void'(notes.pop_front());
        end
    end
    // ==========================================
    // Bus tasks and expectation notes
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic expect_at(int s, logic [9:0] v);
        notes.push_back('{mcyc + 1, s, v});
    endtask
    task automatic wr(logic [8:0] a, logic [7:0] v);
        cb_addr <= a;
        cb_wdata <= v;
        cb_write <= 1'h1;
        tick(1);
        cb_write <= 1'h0;
        tick(1);
    endtask
    task automatic rd(logic [8:0] a);
        cb_addr <= a;
        cb_read <= 1'h1;
        tick(1);
        cb_read <= 1'h0;
        tick(2);
    endtask
    task automatic final_report();
        $display("Compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        d = 8'($urandom(14439));
        tick(10);
        rst <= 1'h0;
        tick(1);
        rd(9'h000);
        expect_at(0, 10'h100);
        expect_at(4, 10'h000);
        wr(9'h000, 8'hFF); // Off ring here
        rd(9'h000);
        expect_at(0, {1'h0, odd(8'hCF), 8'hCF});
        expect_at(4, 10'h00F);
        rd(9'($urandom_range(511, 1)));
        expect_at(0, 10'h100);
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            wr(9'h000, d);
            rd(9'h000);
            expect_at(0, {1'h0, odd(d & 8'hCF), d & 8'hCF});
        end
        // Writes elsewhere must leave the mode untouched
        wr(9'($urandom_range(511, 1)), ~d);
        rd(9'h000);
        expect_at(0, {1'h0, odd(d & 8'hCF), d & 8'hCF});
        wr(9'h000, 8'h09);
        tx_source <= SRC_REPEAT;
        snd_data <= d;
        snd_ctrl <= d[0];
        tick(4);
        expect_at(1, {odd(d), d[0], d});
        expect_at(2, {odd(d), d[0], d});
        expect_at(7, {9'h000, odd(d)});
        spoil <= 1'h1;
        tick(4);
        expect_at(1, 10'h300);
        expect_at(3, 10'h001);
        wr(9'h000, 8'h01);
        tick(3);
        expect_at(1, {~odd(d), d[0], d});
        expect_at(3, 10'h000);
        // Unchecked bad parity is still repeated as is
        expect_at(2, {~odd(d), d[0], d});
        tx_source <= SRC_GENERATE;
        for (int i = 0; i < 4; i++) begin
            g = 8'($urandom);
            tx_gen_data <= g;
            tx_gen_ctrl <= g[1];
            tick(3);
            expect_at(2, {odd(g), g[1], g});
        end
        wr(9'h000, 8'h41);
        tick(4);
        expect_at(1, {odd(g), g[1], g});
        wr(9'h000, 8'h08);
        tick(3);
        expect_at(2, 10'h300);
        wr(9'h000, 8'h80);
        rx_status_live <= 8'hA5;
        tx_status_live <= 8'h5A;
        tick(3);
        expect_at(5, 10'h0A5);
        expect_at(8, 10'h05A);
        receive_sm_error_flag <= 1'h1;
        transmit_sm_error_flag <= 1'h1;
        tick(1);
        rx_status_live <= 8'h3C;
        tx_status_live <= 8'hC3;
        tick(3);
        expect_at(5, 10'h0A5);
        expect_at(8, 10'h05A);
        receive_sm_error_flag <= 1'h0;
        tick(3);
        expect_at(5, 10'h03C);
        expect_at(8, 10'h05A);
        transmit_sm_error_flag <= 1'h0;
        tick(3);
        expect_at(8, 10'h0C3);
        wr(9'h000, 8'h05);
        mac_request_data_in <= 8'h01;
        mac_request_parity_in <= 1'h1;
        mac_request_valid <= 1'h1;
        tick(3);
        expect_at(6, 10'h001);
        mac_request_parity_in <= 1'h0;
        tick(3);
        expect_at(6, 10'h000);
        tick(3);
        final_report();
    end
endmodule
